/* shared/spio_consts.svh */
`ifndef SPIO_CONSTS_SVH
`define SPIO_CONSTS_SVH

// register indices on the plain register port (address = index)
`define SPIO_ADDR_DIR 2'h0
`define SPIO_ADDR_PIN 2'h1
`define SPIO_ADDR_LAT 2'h2
`define SPIO_ADDR_ANA 2'h3

// reset values
`define SPIO_DIR_RESET 16'hffff
`define SPIO_LAT_RESET 16'h0000
`define SPIO_ANA_RESET 16'h0000
`define SPIO_ZERO 16'h0000

// implemented bits of this bank (bits 7:0 are the bank's low general pins)
`define SPIO_IMPL_MASK 16'hf6c0
`define SPIO_LOW_PINS_MASK 16'h00ff
// pins that carry a peripheral output mux
`define SPIO_SHARED_MASK 16'h00c0
// pins that are input-only (external interrupt / reference) dedicated ports
`define SPIO_INONLY_MASK 16'h3000

`endif

/* shared/spio_pkg.sv */
package spio_pkg;
  typedef logic [15:0] spio_word_t;
  typedef logic [1:0] spio_addr_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spio_bus_s;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } spio_pad_s;

  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] drive;
    logic [15:0] data;
  } spio_periph_s;
endpackage

/* logic/spio_pad_sync.sv */
`timescale 1ns/1ps
`include "spio_consts.svh"

// two-stage synchroniser for the pad inputs, one per bit
module spio_pad_sync
  import spio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire spio_word_t padIn,
  output spio_word_t padSync
);
  spio_word_t stageOne;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          stageOne[i] <= 1'b0;
          padSync[i] <= 1'b0;
        end else if (clkEn) begin
          stageOne[i] <= padIn[i];
          padSync[i] <= stageOne[i];
        end
      end
    end
  endgenerate
endmodule

/* logic/spio_port.sv */
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "spio_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - While an enabled peripheral drives a shared pin, the latch cannot reach that pad.
// - The pin-state register still shows a pin's level while a peripheral owns its output.
// - An enabled peripheral that is not driving a pin leaves that pin to the port latch.
// - A direction bit of one makes the pin an input with its port driver off; zero makes it an output.
// - Reset sets every implemented direction bit, so all pins come up as inputs.
// - Reading the latch register returns the latch; writing it updates the latch.
// - Reading the pin-state register returns pad levels; writing it updates the latch.
// - Unimplemented bits are disabled and read as zero in latch, direction and pin-state registers.
// - Each shared pin has muxes choosing peripheral or port for pad data and enable.
// - Pins shared only with input-only functions are plain dedicated ports with no output mux.
// - The bank direction register also steers the low pins and the interrupt and reference pins.
// - Pins set as analog inputs read as zero in the pin-state register.
module spio_port
  import spio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire spio_bus_s bus,
  output spio_word_t rdata,
  input wire spio_periph_s periph,
  input wire spio_word_t padIn,
  output spio_pad_s pad
);

  // bit-selectable copy of the implemented-bit mask
  localparam spio_word_t IMPL_MASK = `SPIO_IMPL_MASK;

  spio_word_t bankADirectionReg;
  spio_word_t bankALatchReg;
  spio_word_t analogSel;
  spio_word_t padSync;
  spio_word_t pinState;
  spio_word_t periphOwns;
  spio_word_t next_padOut;
  spio_word_t next_padOe;
  spio_word_t next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  spio_pad_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .padIn(padIn),
    .padSync(padSync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // direction register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bankADirectionReg <= `SPIO_DIR_RESET & `SPIO_IMPL_MASK;
    end else if (clkEn && bus.wr && bus.addr == `SPIO_ADDR_DIR) begin
      bankADirectionReg <= bus.wdata & `SPIO_IMPL_MASK;
    end
  end

  // output latch: written both at its own address and at the pin-state address
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bankALatchReg <= `SPIO_LAT_RESET;
    end else if (clkEn && bus.wr && (bus.addr == `SPIO_ADDR_LAT || bus.addr == `SPIO_ADDR_PIN)) begin
      bankALatchReg <= bus.wdata & `SPIO_IMPL_MASK;
    end
  end

  // analog input selection, only on low pins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      analogSel <= `SPIO_ANA_RESET;
    end else if (clkEn && bus.wr && bus.addr == `SPIO_ADDR_ANA) begin
      analogSel <= bus.wdata & `SPIO_IMPL_MASK & `SPIO_LOW_PINS_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin-state view: synchronised pads, analog pins and unimplemented bits zero
  assign pinState = padSync & ~analogSel & `SPIO_IMPL_MASK;

  // peripheral owns only shared pins it is enabled on and actively driving
  assign periphOwns = periph.enable & periph.drive & `SPIO_SHARED_MASK;

  // per-pin output muxes
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_mux
      always_comb begin
        if (periphOwns[i]) begin
          next_padOut[i] = periph.data[i];
          next_padOe[i] = 1'b1;
        end else begin
          next_padOut[i] = bankALatchReg[i];
          next_padOe[i] = ~bankADirectionReg[i] & IMPL_MASK[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pad <= '0;
    end else if (clkEn) begin
      pad.out <= next_padOut;
      pad.oe <= next_padOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data: valid the cycle after the read strobe, zero otherwise
  always_comb begin
    case (bus.addr)
      `SPIO_ADDR_DIR: next_rdata = bankADirectionReg;
      `SPIO_ADDR_PIN: next_rdata = pinState;
      `SPIO_ADDR_LAT: next_rdata = bankALatchReg;
      `SPIO_ADDR_ANA: next_rdata = analogSel;
      default: next_rdata = `SPIO_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata <= `SPIO_ZERO;
    end else if (clkEn) begin
      rdata <= bus.rd ? next_rdata : `SPIO_ZERO;
    end
  end

endmodule

/* verification/spio_pad_far.sv */
`timescale 1ns/1ps
module spio_pad_far
  import spio_pkg::*;
(
  input wire spio_pad_s pad,
  input wire spio_word_t extLevel,
  output spio_word_t padIn
);
  assign padIn = (pad.out & pad.oe) | (extLevel & ~pad.oe);
endmodule

/* verification/spio_port_props.sv */
`timescale 1ns/1ps
`include "spio_consts.svh"
module spio_port_props
  import spio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire spio_bus_s bus,
  input wire spio_word_t rdata,
  input wire spio_periph_s periph,
  input wire spio_pad_s pad
);
  logic ok;
  spio_word_t own, im, sh;
  assign im = `SPIO_IMPL_MASK;
  assign sh = `SPIO_SHARED_MASK;
  assign own = periph.enable & periph.drive & sh;
  always_ff @(posedge mclk) ok <= reset_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n || !clkEn);
  AST_OWN: assert property (ok |-> (pad.oe & $past(own)) == $past(own)
    && ((pad.out ^ $past(periph.data)) & $past(own)) == 16'h0) else $error("pad owner");
  AST_UNIMPL: assert property (((pad.oe | rdata) & ~im) == 16'h0) else $error("dead bit");
  AST_IDLE: assert property (ok && !$past(bus.rd) |-> rdata == 16'h0) else $error("stray data");
  AST_RST: assert property (!$past(reset_n) |-> pad.oe == 16'h0) else $error("reset drive");
  AST_LAT: assert property (bus.wr && bus.addr[1] != bus.addr[0] ##1 !bus.wr
    |=> ##1 ((pad.out ^ $past(bus.wdata, 3)) & pad.oe & ~sh) == 16'h0) else $error("pad level");
  AST_DIR: assert property (bus.wr && bus.addr == 2'h0 ##1 !bus.wr
    |=> ##1 ((pad.oe ^ ~$past(bus.wdata, 3)) & im & ~sh) == 16'h0) else $error("direction");
  AST_RBL: assert property (bus.wr && bus.addr == 2'h2 ##1 !bus.wr ##1 bus.rd && bus.addr == 2'h2
    |=> rdata == ($past(bus.wdata, 3) & im)) else $error("latch read");
  AST_RBD: assert property (bus.wr && bus.addr == 2'h0 ##1 !bus.wr ##1 bus.rd && bus.addr == 2'h0
    |=> rdata == ($past(bus.wdata, 3) & im)) else $error("dir read");
endmodule
bind spio_port spio_port_props spio_port_props_i (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .bus(bus),
  .rdata(rdata), .periph(periph), .pad(pad));

/* verification/test_shared_parallel_io_port.sv */
`timescale 1ns/1ps
module test_shared_parallel_io_port
  import spio_pkg::*;
;
  logic mclk, reset_n, clkEn;
  spio_bus_s bus;
  spio_periph_s periph;
  spio_word_t rdata, padIn, extLevel;
  spio_pad_s pad;
  int err_total = 0;
  int cmp_count = 0;
  // write flag, write index, write data, read index, expected read
  logic [36:0] rows [6] = '{{1'h0, 2'h0, 16'h0, 2'h0, 16'hf6c0}, {1'h0, 2'h0, 16'h0, 2'h3, 16'h0},
    {1'h1, 2'h0, 16'h0, 2'h0, 16'h0}, {1'h1, 2'h2, 16'hffff, 2'h2, 16'hf6c0},
    {1'h1, 2'h1, 16'h1234, 2'h2, 16'h1200}, {1'h1, 2'h3, 16'hffff, 2'h3, 16'h00c0}};
  spio_port spio_port_i (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .bus(bus), .rdata(rdata),
    .periph(periph), .padIn(padIn), .pad(pad));
  spio_pad_far spio_pad_far_i (.pad(pad), .extLevel(extLevel), .padIn(padIn));
  task automatic cmp(input spio_word_t got, input spio_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input spio_addr_t a, input spio_word_t d, input spio_word_t exp);
    @(posedge mclk) bus <= '{a, d, w, ~w};
    @(posedge mclk) bus <= '0;
    #1 if (!w) cmp(rdata, exp);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #100us;
    err_total++;
    conclude();
  end
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    bus = '0;
    periph = '0;
    extLevel = 16'haaaa;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][36]) acc(1'b1, rows[i][35:34], rows[i][33:18], 16'h0);
      acc(1'b0, rows[i][17:16], 16'h0, rows[i][15:0]);
    end
    cmp(pad.oe, 16'hf6c0);
    cmp(pad.out, 16'h1200);
    // bit 6 taken by the peripheral, bit 7 enabled but idle, bits 12-13 have no mux
    @(posedge mclk) periph <= '{16'hffff, 16'h3040, 16'h00c0};
    repeat (2) @(posedge mclk);
    #1 cmp(pad.out, 16'h1240);
    acc(1'b1, 2'h0, 16'hffff, 16'h0);
    acc(1'b1, 2'h3, 16'h0080, 16'h0);
    repeat (3) @(posedge mclk);
    acc(1'b0, 2'h1, 16'h0, 16'ha240);
    // pad change launched with the read must not show yet
    @(posedge mclk) bus <= '{2'h1, 16'h0, 1'b0, 1'b1};
    extLevel <= 16'h0;
    @(posedge mclk) bus <= '0;
    #1 cmp(rdata, 16'ha240);
    repeat (2) @(posedge mclk);
    acc(1'b0, 2'h1, 16'h0, 16'h0040);
    // a latch write while the clock enable is low must not land
    @(posedge mclk) clkEn <= 1'b0;
    bus <= '{2'h2, 16'h0000, 1'b1, 1'b0};
    @(posedge mclk) bus <= '0;
    @(posedge mclk) clkEn <= 1'b1;
    acc(1'b0, 2'h2, 16'h0, 16'h1200);
    @(posedge mclk) periph <= '0;
    reset_n <= 1'b0;
    @(posedge mclk) reset_n <= 1'b1;
    acc(1'b0, 2'h0, 16'h0, 16'hf6c0);
    acc(1'b0, 2'h2, 16'h0, 16'h0);
    conclude();
  end
endmodule
